// ---- rtl/pag_pkg.sv ----
/*
  constants, structs and states for the program access guard.
  assumes a 32-bit apb master and one external serial programmer.
*/
package pag_pkg;
  // ==========================================
  // apb register offsets (byte addresses)
  localparam logic [7:0] OFS_TBL_PTR  = 8'h00;
  localparam logic [7:0] OFS_TBL_DATA = 8'h04;
  localparam logic [7:0] OFS_TBL_CTRL = 8'h08;
  localparam logic [7:0] OFS_EE_ADDR  = 8'h0c;
  localparam logic [7:0] OFS_EE_DATA  = 8'h10;
  localparam logic [7:0] OFS_EE_CTRL  = 8'h14;
  localparam logic [7:0] OFS_GPIO     = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;
  // ==========================================
  // table address space
  localparam logic [21:0] ID_FIRST   = 22'h200000;
  localparam logic [21:0] ID_LAST    = 22'h200007;
  localparam logic [21:0] CFG4L_ADDR = 22'h300006;
  localparam logic [21:0] CFG5H_ADDR = 22'h300009;
  localparam logic [21:0] CFG6H_ADDR = 22'h30000b;
  // ==========================================
  // configuration bit positions (protect and debug bits active low)
  localparam int DBG_BIT = 7;
  localparam int LVP_BIT = 2;
  localparam int RDP_BIT = 7;
  localparam int WPE_BIT = 7;
  localparam int WPC_BIT = 5;
  localparam logic [7:0] CFG4L_RST = 8'hff;
  localparam logic [7:0] CFG5H_RST = 8'hff;
  localparam logic [7:0] CFG6H_RST = 8'hff;
  // ==========================================
  // debugger reservations
  localparam logic [1:0] DBG_STACK_LEVELS = 2'h2;
  localparam logic [9:0] DBG_PROG_BYTES   = 10'h240;
  localparam logic [3:0] DBG_DATA_BYTES   = 4'ha;
  // ==========================================
  // serial link frame
  localparam logic [4:0] FRAME_LAST = 5'h13;
  localparam logic [4:0] OUT_LAST   = 5'h07;
  localparam logic [3:0] CMD_EE_RD  = 4'h1;
  localparam logic [3:0] CMD_EE_WR  = 4'h2;
  localparam logic [3:0] CMD_ID_RD  = 4'h3;
  localparam logic [3:0] CMD_ID_WR  = 4'h4;
  localparam logic [3:0] CMD_CFG_RD = 4'h5;
  localparam logic [3:0] CMD_CFG_WR = 4'h6;
  typedef struct packed {
    logic [7:0] w6h;
    logic [7:0] w5h;
    logic [7:0] w4l;
  } cfg_s;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] addr;
    logic [3:0] cmd;
  } frame_s;
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_IN   = 3'b010,
    LK_OUT  = 3'b100
  } link_e;
endpackage : pag_pkg

// ---- rtl/program_access_guard.sv ----
/*
  program access guard: eeprom, id and configuration access control,
  programming entry and debugger reservation, apb slave for the cpu.
  assumes pins arrive asynchronous to pclk and the link clock is slow.
*/
// Local design decisions: the register offsets and register access over APB.
// Notes on behaviour
// - read protect refuses all external eeprom reads and writes
// - write protect refuses external eeprom writes only
// - cpu eeprom access ignores both protect bits
// - config write protect bit stops cpu configuration changes; link writes still land
// - cpu cannot change config write protect; only the link can
// - eight id bytes end at table address 200007h
// - ids reachable by cpu table ops and by the link
// - id reads work regardless of code protection
// - debug enable bit at 0 enables the debugger
// - debugger reserves 2 stack levels, 576 and 10 bytes
// - with lvp set the entry pin is never gpio
// - entry pin high enters programming only when lvp is set
// - lvp bit is 1 when unprogrammed
// - high entry voltage always enters programming
// - with lvp clear the entry pin is plain gpio
// - lvp bit changes only after high voltage entry
// - lvp clear leaves high voltage entry as the only way
module program_access_guard
  import pag_pkg::*;
#(
  parameter int EE_AW = 8
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // programming entry pins
  input  wire logic        master_clear_hv_pin,
  input  wire logic        prog_entry_pin_i,
  output logic             prog_entry_pin_o,
  output logic             prog_entry_pin_oe,
  // serial link pins
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_data_pin_i,
  output logic             serial_data_pin_o,
  output logic             serial_data_pin_oe,
  // mode and debugger status
  output logic             prog_mode,
  output logic             debug_enable,
  output logic      [1:0]  dbg_stack_reserve,
  output logic      [9:0]  dbg_prog_reserve,
  output logic      [3:0]  dbg_data_reserve
);
  // ==========================================
  // storage and state
  logic [7:0]       ee_mem [2**EE_AW];
  logic [7:0]       id_mem [8];
  cfg_s             cfg;
  logic             hv_s1, hv_s2, pg_s1, pg_s2;
  logic             ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;
  logic             hv_entry;
  logic             link_refused;
  link_e            lk_state;
  logic [4:0]       bit_cnt;
  frame_s           shreg;
  logic [7:0]       out_sr;
  logic [21:0]      tbl_ptr;
  logic [7:0]       tbl_latch;
  logic [EE_AW-1:0] ee_addr;
  logic [7:0]       ee_data;
  logic             gpio_out, gpio_dir;
  // ==========================================
  // decode helpers
  function automatic logic is_id(input logic [21:0] a);
    is_id = (a >= ID_FIRST) && (a <= ID_LAST);
  endfunction : is_id

  function automatic logic [7:0] cfg_byte(input cfg_s c, input logic [1:0] i);
    case (i)
      2'h0:    cfg_byte = c.w4l;
      2'h1:    cfg_byte = c.w5h;
      2'h2:    cfg_byte = c.w6h;
      default: cfg_byte = 8'h00;
    endcase
  endfunction : cfg_byte

  logic low_volt_prog_enable, rdp_n, wpe_n, wpc_n;
  assign low_volt_prog_enable   = cfg.w4l[LVP_BIT];
  assign rdp_n = cfg.w5h[RDP_BIT];
  assign wpe_n = cfg.w6h[WPE_BIT];
  assign wpc_n = cfg.w6h[WPC_BIT];
  // ==========================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {hv_s1, hv_s2, pg_s1, pg_s2} <= 4'h0;
      {ck_s1, ck_s2, ck_s3, dt_s1, dt_s2} <= 5'h00;
    end
    else
    begin
      hv_s1 <= master_clear_hv_pin;
      hv_s2 <= hv_s1;
      pg_s1 <= prog_entry_pin_i;
      pg_s2 <= pg_s1;
      ck_s1 <= serial_clock_pin;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      dt_s1 <= serial_data_pin_i;
      dt_s2 <= dt_s1;
    end
  end

  logic ck_rise, ck_fall;
  assign ck_rise = ck_s2 & ~ck_s3;
  assign ck_fall = ~ck_s2 & ck_s3;
  // ==========================================
  // programming entry
  logic next_prog;
  assign next_prog = hv_s2 | (pg_s2 & low_volt_prog_enable);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_mode <= 1'b0;
      hv_entry  <= 1'b0;
    end
    else
    begin
      prog_mode <= next_prog;
      if (!next_prog)
        hv_entry <= 1'b0;
      else if (!prog_mode)
        hv_entry <= hv_s2;  // entry method is kept for the session
    end
  end
  // ==========================================
  // link frame decode
  frame_s     fr;
  logic       fr_end;
  logic [7:0] lk_rd_data;
  logic       lk_is_rd, lk_refuse;
  logic       lk_ee_wr, lk_id_wr, lk_cfg_wr;

  always_comb
  begin
    fr         = frame_s'({dt_s2, shreg[19:1]});
    fr_end     = prog_mode && (lk_state == LK_IN) && ck_rise && (bit_cnt == FRAME_LAST);
    lk_is_rd   = 1'b0;
    lk_refuse  = 1'b0;
    lk_rd_data = 8'h00;
    lk_ee_wr   = 1'b0;
    lk_id_wr   = 1'b0;
    lk_cfg_wr  = 1'b0;
    case (fr.cmd)
      CMD_EE_RD:
      begin
        lk_is_rd   = 1'b1;
        lk_refuse  = ~rdp_n;
        lk_rd_data = rdp_n ? ee_mem[fr.addr[EE_AW-1:0]] : 8'h00;
      end
      CMD_EE_WR:
      begin
        lk_refuse = ~rdp_n | ~wpe_n;
        lk_ee_wr  = fr_end & rdp_n & wpe_n;
      end
      CMD_ID_RD:
      begin
        lk_is_rd   = 1'b1;
        lk_rd_data = id_mem[fr.addr[2:0]];
      end
      CMD_ID_WR:
        lk_id_wr = fr_end;
      CMD_CFG_RD:
      begin
        lk_is_rd   = 1'b1;
        lk_rd_data = cfg_byte(cfg, fr.addr[1:0]);
      end
      CMD_CFG_WR:
        lk_cfg_wr = fr_end;
      default:
        lk_refuse = 1'b1;
    endcase
  end
  // ==========================================
  // serial link engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_state           <= LK_IDLE;
      bit_cnt            <= 5'h00;
      shreg              <= '0;
      out_sr             <= 8'h00;
      serial_data_pin_o  <= 1'b0;
      serial_data_pin_oe <= 1'b0;
      link_refused       <= 1'b0;
    end
    else if (!prog_mode)
    begin
      lk_state           <= LK_IDLE;
      bit_cnt            <= 5'h00;
      serial_data_pin_oe <= 1'b0;
    end
    else
    begin
      case (lk_state)
        LK_IDLE:
        begin
          lk_state     <= LK_IN;
          link_refused <= 1'b0;
        end
        LK_IN:
          if (ck_rise)
          begin
            shreg   <= fr;
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == FRAME_LAST)
            begin
              bit_cnt <= 5'h00;
              if (lk_refuse)
                link_refused <= 1'b1;
              if (lk_is_rd)
              begin
                lk_state           <= LK_OUT;
                out_sr             <= lk_rd_data;
                serial_data_pin_o  <= lk_rd_data[0];
                serial_data_pin_oe <= 1'b1;
              end
            end
          end
        LK_OUT:
        begin
          // data moves after falls so the programmer samples while the clock is high, before each fall
          if (ck_fall)
          begin
            out_sr            <= {1'b0, out_sr[7:1]};
            serial_data_pin_o <= out_sr[1];
          end
          if (ck_rise)
          begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == OUT_LAST)
            begin
              bit_cnt            <= 5'h00;
              lk_state           <= LK_IN;
              serial_data_pin_oe <= 1'b0;
            end
          end
        end
        default:
          lk_state <= LK_IDLE;
      endcase
    end
  end
  // ==========================================
  // apb decode
  logic apb_wr, cpu_tbl_rd, cpu_tbl_wr, cpu_ee_rd, cpu_ee_wr;
  assign apb_wr     = psel & penable & pready & pwrite;
  assign cpu_tbl_rd = apb_wr && (paddr == OFS_TBL_CTRL) && pwdata[0];
  assign cpu_tbl_wr = apb_wr && (paddr == OFS_TBL_CTRL) && pwdata[1];
  assign cpu_ee_rd  = apb_wr && (paddr == OFS_EE_CTRL) && pwdata[0];
  assign cpu_ee_wr  = apb_wr && (paddr == OFS_EE_CTRL) && pwdata[1];
  // ==========================================
  // eeprom and id storage
  always_ff @(posedge pclk)
  begin
    if (lk_ee_wr)
      ee_mem[fr.addr[EE_AW-1:0]] <= fr.data;
    else if (cpu_ee_wr)
      ee_mem[ee_addr] <= ee_data;
  end

  always_ff @(posedge pclk)
  begin
    if (lk_id_wr)
      id_mem[fr.addr[2:0]] <= fr.data;
    else if (cpu_tbl_wr && is_id(tbl_ptr))
      id_mem[tbl_ptr[2:0]] <= tbl_latch;
  end
  // ==========================================
  // configuration storage, reset models the erased part
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg <= cfg_s'({CFG6H_RST, CFG5H_RST, CFG4L_RST});
    else if (lk_cfg_wr)
    begin
      case (fr.addr[1:0])
        2'h0:
        begin
          cfg.w4l <= fr.data;
          if (!hv_entry)
            cfg.w4l[LVP_BIT] <= low_volt_prog_enable;
        end
        2'h1:    cfg.w5h <= fr.data;
        2'h2:    cfg.w6h <= fr.data;
        default: cfg <= cfg;
      endcase
    end
    else if (cpu_tbl_wr && wpc_n)
    begin
      if (tbl_ptr == CFG4L_ADDR)
      begin
        cfg.w4l          <= tbl_latch;
        cfg.w4l[LVP_BIT] <= low_volt_prog_enable;
      end
      if (tbl_ptr == CFG5H_ADDR)
        cfg.w5h <= tbl_latch;
      if (tbl_ptr == CFG6H_ADDR)
      begin
        cfg.w6h          <= tbl_latch;
        cfg.w6h[WPC_BIT] <= wpc_n;
      end
    end
  end
  // ==========================================
  // cpu table and eeprom access registers
  logic [7:0] tbl_rd_data;
  always_comb
  begin
    if (is_id(tbl_ptr))
      tbl_rd_data = id_mem[tbl_ptr[2:0]];
    else if (tbl_ptr == CFG4L_ADDR)
      tbl_rd_data = cfg.w4l;
    else if (tbl_ptr == CFG5H_ADDR)
      tbl_rd_data = cfg.w5h;
    else if (tbl_ptr == CFG6H_ADDR)
      tbl_rd_data = cfg.w6h;
    else
      tbl_rd_data = 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tbl_ptr   <= 22'h000000;
      tbl_latch <= 8'h00;
    end
    else
    begin
      if (apb_wr && paddr == OFS_TBL_PTR)
        tbl_ptr <= pwdata[21:0];
      if (apb_wr && paddr == OFS_TBL_DATA)
        tbl_latch <= pwdata[7:0];
      else if (cpu_tbl_rd)
        tbl_latch <= tbl_rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ee_addr <= '0;
      ee_data <= 8'h00;
    end
    else
    begin
      if (apb_wr && paddr == OFS_EE_ADDR)
        ee_addr <= pwdata[EE_AW-1:0];
      if (apb_wr && paddr == OFS_EE_DATA)
        ee_data <= pwdata[7:0];
      else if (cpu_ee_rd)
        ee_data <= ee_mem[ee_addr];
    end
  end
  // ==========================================
  // entry pin as gpio, and debugger outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpio_out          <= 1'b0;
      gpio_dir          <= 1'b0;
      prog_entry_pin_o  <= 1'b0;
      prog_entry_pin_oe <= 1'b0;
      debug_enable      <= 1'b0;
      dbg_stack_reserve <= 2'h0;
      dbg_prog_reserve  <= 10'h000;
      dbg_data_reserve  <= 4'h0;
    end
    else
    begin
      if (apb_wr && paddr == OFS_GPIO)
      begin
        gpio_out <= pwdata[0];
        gpio_dir <= pwdata[1];
      end
      prog_entry_pin_o  <= gpio_out & ~low_volt_prog_enable;
      prog_entry_pin_oe <= gpio_dir & ~low_volt_prog_enable;
      debug_enable      <= ~cfg.w4l[DBG_BIT];
      dbg_stack_reserve <= cfg.w4l[DBG_BIT] ? 2'h0 : DBG_STACK_LEVELS;
      dbg_prog_reserve  <= cfg.w4l[DBG_BIT] ? 10'h000 : DBG_PROG_BYTES;
      dbg_data_reserve  <= cfg.w4l[DBG_BIT] ? 4'h0 : DBG_DATA_BYTES;
    end
  end
  // ==========================================
  // apb read path, one wait state on every access
  logic [31:0] rd_mux;
  logic        rd_err;
  always_comb
  begin
    rd_err = 1'b0;
    case (paddr)
      OFS_TBL_PTR:  rd_mux = {10'h000, tbl_ptr};
      OFS_TBL_DATA: rd_mux = {24'h000000, tbl_latch};
      OFS_TBL_CTRL: rd_mux = 32'h00000000;
      OFS_EE_ADDR:  rd_mux = 32'(ee_addr);
      OFS_EE_DATA:  rd_mux = {24'h000000, ee_data};
      OFS_EE_CTRL:  rd_mux = 32'h00000000;
      OFS_GPIO:     rd_mux = {29'h00000000, pg_s2 & ~low_volt_prog_enable, gpio_dir, gpio_out};
      OFS_STATUS:   rd_mux = {27'h0000000, low_volt_prog_enable, debug_enable,
                              link_refused, hv_entry, prog_mode};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_err;
      if (psel && penable && !pready && !pwrite)
        prdata <= rd_mux;
    end
  end
endmodule : program_access_guard

// ---- test/guard_monitor.sv ----
/*
  guard_monitor: concurrent checks on the program access guard ports.
  assumes one pclk domain and the bind placed in the bench top file.
*/
module guard_monitor
(
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // pins and status
  input wire logic       master_clear_hv_pin,
  input wire logic       prog_entry_pin_i,
  input wire logic       prog_entry_pin_oe,
  input wire logic       serial_data_pin_oe,
  input wire logic       prog_mode,
  input wire logic       debug_enable,
  input wire logic [1:0] dbg_stack_reserve,
  input wire logic [9:0] dbg_prog_reserve,
  input wire logic [3:0] dbg_data_reserve
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // register bus
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (
    pready |-> pslverr == ((paddr > 8'h1c) || (paddr[1:0] != 2'h0)))
    else $error("pslverr wrong for address");
  // ==========================================
  // debugger and programming entry
  a_debug_reserve: assert property (
    $stable(debug_enable) |-> {dbg_stack_reserve, dbg_prog_reserve, dbg_data_reserve}
      == (debug_enable ? {2'h2, 10'h240, 4'ha} : 16'h0))
    else $error("debugger reservation wrong");
  a_hv_enters: assert property (master_clear_hv_pin [*4] |-> prog_mode)
    else $error("high voltage did not enter programming");
  a_entry_needed: assert property (
    (!master_clear_hv_pin && !prog_entry_pin_i) [*4] |-> !prog_mode)
    else $error("programming without any entry");
  // pin entry implies the enable bit is set, so the pin must not be driven as gpio
  a_lowv_not_gpio: assert property (
    $rose(prog_mode) && !$past(master_clear_hv_pin, 3) |-> !prog_entry_pin_oe)
    else $error("entry pin driven in low voltage mode");
  a_hv_only: assert property (
    !master_clear_hv_pin [*4] ##0 prog_entry_pin_oe |-> !prog_mode)
    else $error("low voltage entry while disabled");
  a_link_quiet: assert property (!prog_mode [*2] |-> !serial_data_pin_oe)
    else $error("link driven outside programming");
endmodule : guard_monitor

// ---- test/serial_programmer.sv ----
/*
  serial_programmer: behavioural external programmer on the two-wire link.
  assumes the bench resolves the data wire from the device output enable.
*/
module serial_programmer
(
  // link pins
  output logic      sclk,
  output logic      sdo,
  input  wire logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // frame driver
  initial
  begin
    sclk = 1'b0;
    sdo  = 1'b0;
  end
  // clock stands low between frames; data set 100 ns before each rise,
  // read bits taken just before each fall since the device moves its bit after a fall
  task automatic frame(input logic [3:0] cmd, input logic [7:0] a, d,
                       output logic [7:0] rd);
    logic [19:0] f;
    f  = {d, a, cmd};
    rd = 8'h0;
    // keep link edges away from pclk edges so the sampling is not a race
    #10;
    for (int i = 0; i < 28; i++)
    begin
      if (i < 20)
        sdo = f[i];
      else
        sdo = ~sdo;  // released: toggle so a stale level never passes for data
      #100 sclk = 1'b1;
      #200;
      if (i >= 19 && i < 27)
        rd[i-19] = line;
      sclk = 1'b0;
      #100;
      if (i == 19 && !cmd[0])
        break;
    end
  endtask : frame
endmodule : serial_programmer

// ---- test/tb_top.sv ----
/*
  tb_top: self-checking bench for the program access guard.
  assumes a 20 MHz pclk, the programmer model and the monitor bind below.
*/
module tb_top
  import pag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, entry_drive;
  logic        master_clear_hv_pin, prog_entry_pin_o, prog_entry_pin_oe, serial_clock_pin;
  logic        host_sdo, serial_data_pin_o, serial_data_pin_oe, prog_mode, debug_enable;
  logic [7:0]  paddr, v;
  logic [31:0] pwdata, prdata, seed;
  logic [1:0]  dbg_stack_reserve;
  logic [9:0]  dbg_prog_reserve;
  logic [3:0]  dbg_data_reserve;
  logic [33:0] qe;
  logic [33:0] expq[$];
  int          n_fail, num_checks;
  wire logic   prog_entry_pin_i, serial_data_pin_i;
  // ==========================================
  // wires, design and partner
  assign prog_entry_pin_i  = prog_entry_pin_oe ? prog_entry_pin_o : entry_drive;
  assign serial_data_pin_i = serial_data_pin_oe ? serial_data_pin_o : host_sdo;
  program_access_guard DUT
  (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .master_clear_hv_pin, .prog_entry_pin_i, .prog_entry_pin_o,
    .prog_entry_pin_oe, .serial_clock_pin, .serial_data_pin_i, .serial_data_pin_o,
    .serial_data_pin_oe, .prog_mode, .debug_enable, .dbg_stack_reserve,
    .dbg_prog_reserve, .dbg_data_reserve
  );
  serial_programmer prg (.sclk(serial_clock_pin), .sdo(host_sdo), .line(serial_data_pin_i));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ==========================================
  // checking
  task automatic chk(input logic [33:0] e, g);
    num_checks++;
    if (e !== g)
    begin
      n_fail++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task end_of_test;
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // write data is not compared, only the error flag
  always @(posedge pclk)
    if (pready === 1'b1)
    begin
      qe = expq.pop_front();
      chk(qe, {qe[33], pslverr, qe[33] ? qe[31:0] : prdata});
    end
  initial
  begin
    #1ms;
    n_fail++;
    end_of_test;
  end
  // ==========================================
  // drivers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    expq.push_back({w, e});
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    penable <= 1'b0;
  endtask : apb
  task idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle
  task tbl(input logic [21:0] a, input logic w, input logic [7:0] d, x);
    apb(1'b1, OFS_TBL_PTR, {10'h0, a}, 33'h0);
    apb(1'b1, OFS_TBL_DATA, {24'h0, d}, 33'h0);
    if (w)
      apb(1'b1, OFS_TBL_CTRL, 32'h2, 33'h0);
    apb(1'b1, OFS_TBL_CTRL, 32'h1, 33'h0);
    apb(1'b0, OFS_TBL_DATA, 32'h0, {25'h0, x});
  endtask : tbl
  task ee(input logic [7:0] a, d, x);
    apb(1'b1, OFS_EE_ADDR, {24'h0, a}, 33'h0);
    apb(1'b1, OFS_EE_DATA, {24'h0, d}, 33'h0);
    apb(1'b1, OFS_EE_CTRL, 32'h2, 33'h0);
    apb(1'b1, OFS_EE_DATA, 32'h0, 33'h0);
    apb(1'b1, OFS_EE_CTRL, 32'h1, 33'h0);
    apb(1'b0, OFS_EE_DATA, 32'h0, {25'h0, x});
  endtask : ee
  task lk(input logic [3:0] c, input logic [7:0] a, d, x);
    logic [7:0] r;
    psel <= 1'b0;
    prg.frame(c, a, d, r);
    if (c[0])
      chk({26'h0, x}, {26'h0, r});
    @(posedge pclk);
  endtask : lk
  // ==========================================
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    master_clear_hv_pin = 1'b0;
    entry_drive = 1'b0;
    seed = 32'h00013d27;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    seed = lfsr(lfsr(seed));
    v = seed[7:0];
    apb(1'b0, OFS_STATUS, 32'h0, 33'h10);
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h24, seed, {1'b1, 32'h0});
    tbl(CFG4L_ADDR, 1'b0, 8'h0, CFG4L_RST);
    tbl(ID_LAST, 1'b1, v, v);
    tbl(ID_LAST + 22'h1, 1'b1, v, 8'h0);
    ee(8'h03, 8'h3c, 8'h3c);
    tbl(CFG6H_ADDR, 1'b1, 8'hdf, 8'hff);
    tbl(CFG4L_ADDR, 1'b1, 8'h7b, 8'h7f);
    apb(1'b1, OFS_GPIO, 32'h3, 33'h0);
    idle(2);
    chk(34'h2, {32'h0, debug_enable, prog_entry_pin_oe});
    chk({18'h0, 2'h2, 10'h240, 4'ha}, {18'h0, dbg_stack_reserve, dbg_prog_reserve,
        dbg_data_reserve});
    entry_drive <= 1'b1;
    idle(6);
    apb(1'b0, OFS_STATUS, 32'h0, 33'h19);
    lk(CMD_EE_RD, 8'h03, 8'h0, 8'h3c);
    lk(CMD_CFG_WR, 8'h02, 8'h5f, 8'h0);
    lk(CMD_EE_WR, 8'h03, 8'h99, 8'h0);
    lk(CMD_EE_RD, 8'h03, 8'h0, 8'h3c);
    lk(CMD_CFG_WR, 8'h01, 8'h7f, 8'h0);
    lk(CMD_EE_RD, 8'h03, 8'h0, 8'h00);
    lk(CMD_CFG_WR, 8'h00, 8'h7b, 8'h0);
    lk(CMD_CFG_RD, 8'h00, 8'h0, 8'h7f);
    lk(CMD_ID_RD, 8'h07, 8'h0, v);
    apb(1'b0, OFS_STATUS, 32'h0, 33'h1d);
    entry_drive <= 1'b0;
    idle(6);
    ee(8'h03, v, v);
    tbl(CFG4L_ADDR, 1'b1, 8'hff, 8'h7f);
    tbl(ID_LAST, 1'b0, 8'h0, v);
    master_clear_hv_pin <= 1'b1;
    idle(6);
    lk(CMD_CFG_WR, 8'h00, 8'h7b, 8'h0);
    lk(CMD_CFG_RD, 8'h00, 8'h0, 8'h7b);
    lk(CMD_ID_WR, 8'h00, ~v, 8'h0);
    lk(CMD_ID_RD, 8'h00, 8'h0, ~v);
    lk(4'h8, 8'h00, 8'h0, 8'h0);
    apb(1'b0, OFS_STATUS, 32'h0, 33'h0f);
    lk(CMD_CFG_WR, 8'h01, 8'hff, 8'h0);
    lk(CMD_CFG_WR, 8'h02, 8'hff, 8'h0);
    lk(CMD_EE_WR, 8'h03, 8'h5a, 8'h0);
    lk(CMD_EE_RD, 8'h03, 8'h0, 8'h5a);
    master_clear_hv_pin <= 1'b0;
    entry_drive <= 1'b1;
    idle(6);
    apb(1'b0, OFS_STATUS, 32'h0, 33'h0c);
    apb(1'b1, OFS_GPIO, 32'h3, 33'h0);
    apb(1'b0, OFS_GPIO, 32'h0, 33'h7);
    apb(1'b1, OFS_GPIO, 32'h2, 33'h0);
    idle(2);
    chk(34'h2, {32'h0, prog_entry_pin_oe, prog_entry_pin_o});
    apb(1'b0, OFS_GPIO, 32'h0, 33'h2);
    idle(2);
    end_of_test;
  end
endmodule : tb_top

bind program_access_guard guard_monitor mon
(
  .pclk, .presetn, .paddr, .psel, .penable, .pready, .pslverr, .master_clear_hv_pin,
  .prog_entry_pin_i, .prog_entry_pin_oe, .serial_data_pin_oe, .prog_mode, .debug_enable,
  .dbg_stack_reserve, .dbg_prog_reserve, .dbg_data_reserve
);
